// ==== core/usbef_top.sv ====
// Functional notes
// [RQ1] write one clears a flag; reading status, attribute or detect registers clears related flags
// [RQ2] setup flag bit 31 sets on setup, held until one written there
// [RQ3] bits 21:16 flag endpoint 0..5 events; cleared by one there or bit 1
// [RQ4] event kind readable in three-bit per-endpoint status field, ep0 at 10:8
// [RQ5] wakeup flag bit 3 latches, held until one written there
// [RQ6] attach or detach latches bit 2, cleared by writing one
// [RQ7] bit 1 sets on any transaction event, kind in endpoint fields
// [RQ8] bit 1 clears on one to bit 1, or clearing all endpoint and setup flags
// [RQ9] bit 0 sets on suspend or resume; kind in bus attribute low nibble
// [RQ10] bus, transaction, detect, wakeup interrupts gated by enable bits 0..3
// [RQ11] in-nak enable decides whether nak to IN token is reported
// [RQ12] reserved bits read zero and ignore writes
`default_nettype none

module usbef_top
  import usbef_pkg::*;
(
  input  wire logic                     CLK_SYS_IN,          // 125 MHz clock
  input  wire logic                     RST_N_IN,            // async reset, active low
  input  wire logic [ADDR_W-1:0]        AVS_ADDRESS_IN,      // byte address
  input  wire logic                     AVS_READ_IN,         // read request
  input  wire logic                     AVS_WRITE_IN,        // write request
  input  wire logic [DATA_W-1:0]        AVS_WRITEDATA_IN,    // write data
  input  wire logic [BE_W-1:0]          AVS_BYTEENABLE_IN,   // byte lanes
  output logic      [DATA_W-1:0]        AVS_READDATA_OUT,    // read data
  output logic                          AVS_WAITREQUEST_OUT, // stall, active high
  input  wire logic                     SETUP_EVT_IN,        // setup transaction pulse
  input  wire usbef_pkg::usbef_ep_event_type EP_EVT_IN,      // endpoint event
  input  wire logic                     WAKEUP_EVT_IN,       // wakeup pulse
  input  wire logic                     FLOAT_DET_IN,        // cable attached level
  input  wire logic                     BUS_EVT_IN,          // suspend/resume pulse
  input  wire logic [BUSKIND_W-1:0]     BUS_KIND_IN,         // bus event kind
  output logic                          IRQ_OUT              // interrupt level
);
  import usbef_pkg::*;

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // bus slave: one wait cycle, answer on the second edge
  // ------------------------------------------------------------------
  logic              wait_q;
  logic              wait_d;
  logic              req;
  logic              rd_acc;
  logic              wr_acc;
  logic [DATA_W-1:0] be_mask;
  logic [DATA_W-1:0] wdata;
  logic              hit_en;
  logic              hit_flags;
  logic              hit_eps;
  logic              hit_attr;
  logic              hit_fdet;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_q;

  assign req       = AVS_READ_IN | AVS_WRITE_IN;
  assign wait_d    = ~(req & wait_q);
  assign rd_acc    = AVS_READ_IN & ~wait_q;
  assign wr_acc    = AVS_WRITE_IN & ~wait_q;
  assign be_mask   = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
                      {8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
  assign wdata     = AVS_WRITEDATA_IN & be_mask;
  assign hit_en    = AVS_ADDRESS_IN == OFS_INT_ENABLE;
  assign hit_flags = AVS_ADDRESS_IN == OFS_EVENT_FLAGS;
  assign hit_eps   = AVS_ADDRESS_IN == OFS_EP_STATUS;
  assign hit_attr  = AVS_ADDRESS_IN == OFS_BUS_ATTR;
  assign hit_fdet  = AVS_ADDRESS_IN == OFS_FLOAT_DET;

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= UNMAPPED_DATA;
    end else begin
      wait_q <= wait_d;
      if (AVS_READ_IN && wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign AVS_WAITREQUEST_OUT = wait_q;
  assign AVS_READDATA_OUT    = rdata_q;

  // ------------------------------------------------------------------
  // interrupt enable register
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] en_q;
  logic [DATA_W-1:0] en_d;
  logic              wake_fn_en;
  logic              in_nak_en;

  // [RQ12] only implemented bits stored
  assign en_d = (wr_acc && hit_en) ?
                ((en_q & ~be_mask) | wdata) & ENABLE_IMPL_MASK : en_q;
  assign wake_fn_en = en_q[BIT_WAKE_FN];
  assign in_nak_en  = en_q[BIT_IN_NAK];

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= ENABLE_RST;
    end else begin
      en_q <= en_d;
    end
  end

  // ------------------------------------------------------------------
  // endpoint events and status fields
  // ------------------------------------------------------------------
  logic                 ep_ok;
  logic [EP_NUM-1:0]    ep_hit;
  logic [EPS_W-1:0]     eps_q [EP_NUM];
  logic [EP_NUM*EPS_W-1:0] eps_flat;

  // [RQ11] nak to IN reported only when enabled
  assign ep_ok = EP_EVT_IN.valid && (EP_EVT_IN.ep < EPN_W'(EP_NUM)) &&
                 ((EP_EVT_IN.code != EPS_IN_NAK) || in_nak_en);

  for (genvar e = 0; e < EP_NUM; e++) begin : g_ep
    assign ep_hit[e] = ep_ok && (EP_EVT_IN.ep == EPN_W'(e));
    assign eps_flat[e*EPS_W +: EPS_W] = eps_q[e];
    // [RQ4] record event kind
    always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
      if (!rst_n) begin
        eps_q[e] <= EPS_IN_ACK;
      end else if (ep_hit[e]) begin
        eps_q[e] <= EP_EVT_IN.code;
      end
    end
  end

  // ------------------------------------------------------------------
  // attach/detach edge and bus attribute
  // ------------------------------------------------------------------
  logic                 fdet_prev_q;
  logic                 fdet_seen_q;
  logic                 fdet_edge;
  logic [BUSKIND_W-1:0] bus_kind_q;

  // first sample after reset only arms the detector
  assign fdet_edge = fdet_seen_q && (FLOAT_DET_IN != fdet_prev_q);

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      fdet_prev_q <= 1'b0;
      fdet_seen_q <= 1'b0;
      bus_kind_q  <= '0;
    end else begin
      fdet_prev_q <= FLOAT_DET_IN;
      fdet_seen_q <= 1'b1;
      // [RQ9] keep bus event kind
      if (BUS_EVT_IN) begin
        bus_kind_q <= BUS_KIND_IN;
      end
    end
  end

  // ------------------------------------------------------------------
  // event flags
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] flags_q;
  logic [DATA_W-1:0] flags_d;
  logic [DATA_W-1:0] set_v;
  logic [DATA_W-1:0] clr_v;
  logic [DATA_W-1:0] w1c;
  logic              rd_clr_ep;
  logic              rd_clr_bus;
  logic              rd_clr_fdet;
  logic              grp_clear;

  assign w1c         = (wr_acc && hit_flags) ? wdata : '0;
  assign rd_clr_ep   = rd_acc && hit_eps;
  assign rd_clr_bus  = rd_acc && hit_attr;
  assign rd_clr_fdet = rd_acc && hit_fdet;
  // clearing the last endpoint/setup flag also retires bit 1
  assign grp_clear   = |(w1c & EP_SETUP_MASK) &&
                       ((flags_q & ~w1c & EP_SETUP_MASK) == '0);

  always_comb begin
    set_v = '0;
    // [RQ2] setup event
    set_v[BIT_SETUP] = SETUP_EVT_IN;
    // [RQ3] endpoint event
    set_v[BIT_EP0 +: EP_NUM] = ep_hit;
    // [RQ7] any transaction
    set_v[BIT_TRANS] = SETUP_EVT_IN | ep_ok;
    // [RQ6] attach or detach
    set_v[BIT_ATTACH] = fdet_edge;
    // [RQ5] wakeup only while wakeup enabled
    set_v[BIT_WAKEUP] = WAKEUP_EVT_IN & wake_fn_en;
    // [RQ9] suspend or resume
    set_v[BIT_BUS] = BUS_EVT_IN;
  end

  always_comb begin
    // [RQ1] write one clears
    clr_v = w1c;
    // [RQ3] bit 1 or status read clears endpoints
    clr_v[BIT_EP0 +: EP_NUM] = w1c[BIT_EP0 +: EP_NUM] |
                               {EP_NUM{w1c[BIT_TRANS] | rd_clr_ep}};
    // [RQ8] transaction flag clear paths
    clr_v[BIT_TRANS] = w1c[BIT_TRANS] | rd_clr_ep | grp_clear;
    // [RQ1] register reads clear related flags
    clr_v[BIT_BUS]    = w1c[BIT_BUS] | rd_clr_bus;
    clr_v[BIT_ATTACH] = w1c[BIT_ATTACH] | rd_clr_fdet;
  end

  usbef_flag_cell u_flags (
    .clk_in      (CLK_SYS_IN),
    .rst_n_in    (rst_n),
    .set_in      (set_v),
    .clr_in      (clr_v),
    .flags_d_out (flags_d),
    .flags_q_out (flags_q)
  );

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] eps_word;

  assign eps_word = {{(DATA_W-EPS_BASE-EP_NUM*EPS_W){1'b0}}, eps_flat,
                     {EPS_BASE{1'b0}}};
  assign rd_mux = hit_en    ? en_q :
                  hit_flags ? flags_q :
                  hit_eps   ? eps_word :
                  hit_attr  ? {{(DATA_W-BUSKIND_W){1'b0}}, bus_kind_q} :
                  hit_fdet  ? {{(DATA_W-1){1'b0}}, FLOAT_DET_IN} :
                  UNMAPPED_DATA;

  // ------------------------------------------------------------------
  // interrupt output
  // ------------------------------------------------------------------
  logic irq_q;

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      // [RQ10] gated by enable bits
      irq_q <= |(flags_d[INT_SRC_W-1:0] & en_d[INT_SRC_W-1:0]);
    end
  end

  assign IRQ_OUT = irq_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_setup_held;
    @(posedge CLK_SYS_IN) disable iff (!rst_n)
    SETUP_EVT_IN ##1 !w1c[BIT_SETUP] [*2] |-> flags_q[BIT_SETUP];
  endproperty
  a_setup_held: assert property (p_setup_held) // [RQ2]
    else $error("setup flag lost without write one");

  property p_fdet_read_clears;
    @(posedge CLK_SYS_IN) disable iff (!rst_n)
    rd_clr_fdet && !fdet_edge |=> !flags_q[BIT_ATTACH];
  endproperty
  a_fdet_read_clears: assert property (p_fdet_read_clears) // [RQ1]
    else $error("detect read did not clear flag");

  property p_ep_sets;
    @(posedge CLK_SYS_IN) disable iff (!rst_n)
    ep_ok |=> flags_q[BIT_EP0 + $past(EP_EVT_IN.ep)];
  endproperty
  a_ep_sets: assert property (p_ep_sets) // [RQ3]
    else $error("endpoint flag not set");

  property p_ep_code;
    @(posedge CLK_SYS_IN) disable iff (!rst_n)
    ep_ok |=> eps_word[EPS_BASE + EPS_W*$past(EP_EVT_IN.ep) +: EPS_W]
              == $past(EP_EVT_IN.code);
  endproperty
  a_ep_code: assert property (p_ep_code) // [RQ4]
    else $error("endpoint status field wrong");

  property p_wake_held;
    @(posedge CLK_SYS_IN) disable iff (!rst_n)
    flags_q[BIT_WAKEUP] && !w1c[BIT_WAKEUP] |=> flags_q[BIT_WAKEUP];
  endproperty
  a_wake_held: assert property (p_wake_held) // [RQ5]
    else $error("wakeup flag dropped");

  property p_attach_sets;
    @(posedge CLK_SYS_IN) disable iff (!rst_n)
    $changed(FLOAT_DET_IN) && fdet_seen_q |=> flags_q[BIT_ATTACH];
  endproperty
  a_attach_sets: assert property (p_attach_sets) // [RQ6]
    else $error("attach flag not set");

  property p_trans_sets;
    @(posedge CLK_SYS_IN) disable iff (!rst_n)
    (ep_ok || SETUP_EVT_IN) |=> flags_q[BIT_TRANS];
  endproperty
  a_trans_sets: assert property (p_trans_sets) // [RQ7]
    else $error("transaction flag not set");

  property p_trans_clear;
    @(posedge CLK_SYS_IN) disable iff (!rst_n)
    w1c[BIT_TRANS] && !ep_ok && !SETUP_EVT_IN |=>
      !flags_q[BIT_TRANS] && (flags_q[BIT_EP0 +: EP_NUM] == '0);
  endproperty
  a_trans_clear: assert property (p_trans_clear) // [RQ8]
    else $error("bit 1 write did not clear");

  property p_bus_event;
    @(posedge CLK_SYS_IN) disable iff (!rst_n)
    BUS_EVT_IN |=> flags_q[BIT_BUS] && bus_kind_q == $past(BUS_KIND_IN);
  endproperty
  a_bus_event: assert property (p_bus_event) // [RQ9]
    else $error("bus event not recorded");

  property p_irq_gate;
    @(posedge CLK_SYS_IN) disable iff (!rst_n)
    IRQ_OUT == |(flags_q[INT_SRC_W-1:0] & en_q[INT_SRC_W-1:0]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) // [RQ10]
    else $error("interrupt level mismatch");

  property p_nak_ignored;
    @(posedge CLK_SYS_IN) disable iff (!rst_n)
    EP_EVT_IN.valid && EP_EVT_IN.code == EPS_IN_NAK && !in_nak_en
      |=> $stable(eps_flat);
  endproperty
  a_nak_ignored: assert property (p_nak_ignored) // [RQ11]
    else $error("suppressed nak changed status");

  property p_rsvd_zero;
    @(posedge CLK_SYS_IN) disable iff (!rst_n)
    (flags_q & ~FLAGS_IMPL_MASK) == '0 && (en_q & ~ENABLE_IMPL_MASK) == '0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // [RQ12]
    else $error("reserved bit set");

endmodule

`default_nettype wire

// ==== core/usbef_pkg.sv ====
`default_nettype none

package usbef_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned BE_W      = 4;
  localparam int unsigned EP_NUM    = 6;
  localparam int unsigned EPS_W     = 3;
  localparam int unsigned EPN_W     = 3;
  localparam int unsigned BUSKIND_W = 4;
  localparam int unsigned INT_SRC_W = 4;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_INT_ENABLE  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EP_STATUS   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_BUS_ATTR    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FLOAT_DET   = 8'h14;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int unsigned BIT_BUS      = 0;
  localparam int unsigned BIT_TRANS    = 1;
  localparam int unsigned BIT_ATTACH   = 2;
  localparam int unsigned BIT_WAKEUP   = 3;
  localparam int unsigned BIT_EP0      = 16;
  localparam int unsigned BIT_SETUP    = 31;
  localparam int unsigned BIT_WAKE_FN  = 8;
  localparam int unsigned BIT_IN_NAK   = 15;
  localparam int unsigned EPS_BASE     = 8;

  // ------------------------------------------------------------------
  // masks and reset values
  // ------------------------------------------------------------------
  localparam logic [DATA_W-1:0] FLAGS_IMPL_MASK  = 32'h803F000F;
  localparam logic [DATA_W-1:0] EP_SETUP_MASK    = 32'h803F0000;
  localparam logic [DATA_W-1:0] ENABLE_IMPL_MASK = 32'h0000810F;
  localparam logic [DATA_W-1:0] FLAGS_RST        = 32'h00000000;
  localparam logic [DATA_W-1:0] ENABLE_RST       = 32'h00000000;
  localparam logic [DATA_W-1:0] UNMAPPED_DATA    = 32'h00000000;

  // ------------------------------------------------------------------
  // endpoint status codes
  // ------------------------------------------------------------------
  localparam logic [EPS_W-1:0] EPS_IN_ACK   = 3'h0;
  localparam logic [EPS_W-1:0] EPS_IN_NAK   = 3'h1;
  localparam logic [EPS_W-1:0] EPS_OUT0_ACK = 3'h2;
  localparam logic [EPS_W-1:0] EPS_SETUP    = 3'h3;
  localparam logic [EPS_W-1:0] EPS_OUT1_ACK = 3'h6;
  localparam logic [EPS_W-1:0] EPS_ISO_END  = 3'h7;

  typedef struct packed {
    logic             valid;
    logic [EPN_W-1:0] ep;
    logic [EPS_W-1:0] code;
  } usbef_ep_event_type;

endpackage

`default_nettype wire

// ==== core/usbef_flag_cell.sv ====
`default_nettype none

module usbef_flag_cell
  import usbef_pkg::*;
(
  input  wire logic              clk_in,      // system clock
  input  wire logic              rst_n_in,    // synchronised reset, active low
  input  wire logic [DATA_W-1:0] set_in,      // hardware set per bit
  input  wire logic [DATA_W-1:0] clr_in,      // software clear per bit
  output logic      [DATA_W-1:0] flags_d_out, // next flag value
  output logic      [DATA_W-1:0] flags_q_out  // current flag value
);

  // ------------------------------------------------------------------
  // sticky bits
  // ------------------------------------------------------------------
  for (genvar i = 0; i < DATA_W; i++) begin : g_bit
    if (FLAGS_IMPL_MASK[i]) begin : g_impl
      // set beats clear so no event is lost
      assign flags_d_out[i] = set_in[i] | (flags_q_out[i] & ~clr_in[i]);
    end else begin : g_rsvd
      // [RQ12] reserved reads zero
      assign flags_d_out[i] = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_q_out <= FLAGS_RST;
    end else begin
      flags_q_out <= flags_d_out;
    end
  end

endmodule

`default_nettype wire

// ==== bench/usbef_host_model.sv ====
`default_nettype none

module usbef_host_model
  import usbef_pkg::*;
(
  input  wire logic                    clk_in,     // system clock
  output logic                         setup_out,  // setup transaction pulse
  output usbef_pkg::usbef_ep_event_type ep_out,    // endpoint event pulse
  output logic                         wake_out,   // wakeup pulse
  output logic                         attach_out, // cable present level
  output logic                         bus_out,    // suspend/resume pulse
  output logic [BUSKIND_W-1:0]         kind_out    // bus event kind
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    setup_out  = 1'b0;
    ep_out     = '0;
    wake_out   = 1'b0;
    attach_out = 1'b0;
    bus_out    = 1'b0;
    kind_out   = 4'hA;
  end

  // ------------------------------------------------------------------
  // one bus happening: 0 setup, 1 endpoint, 2 wakeup, 3 cable, 4 bus
  // ------------------------------------------------------------------
  // qualifiers are scrambled afterwards so a stale value never looks valid
  task automatic fire(input int k, input logic [7:0] v);
    case (k)
      0: setup_out <= 1'b1;
      1: ep_out <= '{valid: 1'b1, ep: v[5:3], code: v[2:0]};
      2: wake_out <= 1'b1;
      3: attach_out <= ~attach_out;
      default: begin
        bus_out  <= 1'b1;
        kind_out <= v[3:0];
      end
    endcase
    @(posedge clk_in);
    setup_out <= 1'b0;
    ep_out    <= '{valid: 1'b0, ep: ~v[5:3], code: ~v[2:0]};
    wake_out  <= 1'b0;
    bus_out   <= 1'b0;
    kind_out  <= ~v[3:0];
    @(posedge clk_in);
  endtask

endmodule

`default_nettype wire

// ==== bench/testbench.sv ====
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import usbef_pkg::*;

  logic               clk;
  logic               rst_n;
  logic [7:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [3:0]         avs_byteenable;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic               setup_evt;
  usbef_ep_event_type ep_evt;
  logic               wake_evt;
  logic               attach;
  logic               bus_evt;
  logic [3:0]         bus_kind;
  logic               irq;
  int                 failures = 0;
  int                 checks = 0;
  int                 cycles = 0;
  logic [7:0]         offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'hFC};
  logic [2:0]         codes [6] = '{EPS_IN_ACK, EPS_IN_NAK, EPS_OUT0_ACK, EPS_SETUP,
                                    EPS_OUT1_ACK, EPS_ISO_END};
  int                 src [4] = '{4, 0, 3, 2};

  usbef_top i_usbef_top (
    .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(avs_address),
    .AVS_READ_IN(avs_read), .AVS_WRITE_IN(avs_write), .AVS_WRITEDATA_IN(avs_writedata),
    .AVS_BYTEENABLE_IN(avs_byteenable), .AVS_READDATA_OUT(avs_readdata),
    .AVS_WAITREQUEST_OUT(avs_waitrequest), .SETUP_EVT_IN(setup_evt), .EP_EVT_IN(ep_evt),
    .WAKEUP_EVT_IN(wake_evt), .FLOAT_DET_IN(attach), .BUS_EVT_IN(bus_evt),
    .BUS_KIND_IN(bus_kind), .IRQ_OUT(irq)
  );

  usbef_host_model i_usbef_host_model (
    .clk_in(clk), .setup_out(setup_evt), .ep_out(ep_evt), .wake_out(wake_evt),
    .attach_out(attach), .bus_out(bus_evt), .kind_out(bus_kind)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // called right after a rising edge; holds the request until waitrequest is low
  // no local limit: only the cycle ceiling ends a hung wait
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= ~wr;
    avs_writedata  <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    access(1'b0, a, 32'h0, 4'hF, q);
    check(q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, a, d, 4'hF, q);
  endtask

  function automatic logic [31:0] put_field(input logic [31:0] w, input int e,
                                            input logic [2:0] c);
    logic [31:0] r;
    r = w;
    r[EPS_BASE + 3 * e +: 3] = c;
    return r;
  endfunction

  function automatic logic [31:0] ep_flags(input int e);
    return 32'h2 | (32'h1 << (BIT_EP0 + e));
  endfunction

  task automatic summarize();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // a run of this length needs well under 5000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic [31:0] eps;
    int          ep;
    logic [2:0]  code;
    logic [3:0]  kind;
    rst_n = 1'b0;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    eps = 32'h0;
    q = $urandom(32'h5B0200F9);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (offs[i]) rd(offs[i], 32'h0);
    wr(OFS_EVENT_FLAGS, 32'hFFFFFFFF);
    rd(OFS_EVENT_FLAGS, 32'h0);
    wr(OFS_INT_ENABLE, 32'hFFFFFFFF);
    rd(OFS_INT_ENABLE, ENABLE_IMPL_MASK);
    for (int i = 0; i < 24; i++) begin
      ep = $urandom_range(5, 0);
      code = codes[$urandom_range(5, 0)];
      i_usbef_host_model.fire(1, {2'b00, ep[2:0], code});
      eps = put_field(eps, ep, code);
      check({31'h0, irq}, 32'h1);
      rd(OFS_EVENT_FLAGS, ep_flags(ep));
      if (i % 2) begin
        rd(OFS_EP_STATUS, eps);
      end else begin
        wr(OFS_EVENT_FLAGS, 32'h1 << (BIT_EP0 + ep));
      end
      rd(OFS_EVENT_FLAGS, 32'h0);
    end
    // endpoint numbers past five do not exist
    i_usbef_host_model.fire(1, 8'h37);
    rd(OFS_EVENT_FLAGS, 32'h0);
    i_usbef_host_model.fire(0, 8'h00);
    i_usbef_host_model.fire(1, {2'b00, 3'd4, EPS_OUT0_ACK});
    eps = put_field(eps, 4, EPS_OUT0_ACK);
    rd(OFS_EVENT_FLAGS, 32'h80100002);
    wr(OFS_EVENT_FLAGS, 32'h80000000);
    rd(OFS_EVENT_FLAGS, 32'h00100002);
    i_usbef_host_model.fire(0, 8'h00);
    wr(OFS_EVENT_FLAGS, 32'h00000002);
    rd(OFS_EVENT_FLAGS, 32'h80000000);
    rd(OFS_EP_STATUS, eps);
    access(1'b1, OFS_EVENT_FLAGS, 32'hFFFFFFFF, 4'h7, q);
    rd(OFS_EVENT_FLAGS, 32'h80000000);
    wr(OFS_EVENT_FLAGS, 32'h80000000);
    rd(OFS_EVENT_FLAGS, 32'h0);
    wr(OFS_INT_ENABLE, 32'h0000800F);
    i_usbef_host_model.fire(2, 8'h00);
    rd(OFS_EVENT_FLAGS, 32'h0);
    wr(OFS_INT_ENABLE, 32'h0000810F);
    i_usbef_host_model.fire(2, 8'h00);
    rd(OFS_EP_STATUS, eps);
    rd(OFS_EVENT_FLAGS, 32'h00000008);
    wr(OFS_EVENT_FLAGS, 32'h00000008);
    rd(OFS_EVENT_FLAGS, 32'h0);
    i_usbef_host_model.fire(3, 8'h00);
    rd(OFS_EVENT_FLAGS, 32'h00000004);
    rd(OFS_FLOAT_DET, 32'h00000001);
    rd(OFS_EVENT_FLAGS, 32'h0);
    i_usbef_host_model.fire(3, 8'h00);
    rd(OFS_EVENT_FLAGS, 32'h00000004);
    wr(OFS_EVENT_FLAGS, 32'h00000004);
    rd(OFS_EVENT_FLAGS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      kind = $urandom_range(15, 0);
      i_usbef_host_model.fire(4, {4'h0, kind});
      rd(OFS_EVENT_FLAGS, 32'h00000001);
      rd(OFS_BUS_ATTR, {28'h0, kind});
      rd(OFS_EVENT_FLAGS, 32'h0);
    end
    wr(OFS_INT_ENABLE, 32'h0000010F);
    i_usbef_host_model.fire(1, {2'b00, 3'd3, EPS_IN_NAK});
    rd(OFS_EVENT_FLAGS, 32'h0);
    rd(OFS_EP_STATUS, eps);
    wr(OFS_INT_ENABLE, 32'h0000810F);
    i_usbef_host_model.fire(1, {2'b00, 3'd3, EPS_IN_NAK});
    eps = put_field(eps, 3, EPS_IN_NAK);
    rd(OFS_EVENT_FLAGS, 32'h00080002);
    rd(OFS_EP_STATUS, eps);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_INT_ENABLE, 32'h00008100 | (32'h1 << s));
      for (int k = 0; k < 4; k++) begin
        if (k != s) i_usbef_host_model.fire(src[k], 8'h05);
      end
      check({31'h0, irq}, 32'h0);
      i_usbef_host_model.fire(src[s], 8'h05);
      check({31'h0, irq}, 32'h1);
      wr(OFS_EVENT_FLAGS, 32'hFFFFFFFF);
    end
    rd(OFS_EVENT_FLAGS, 32'h0);
    check({31'h0, irq}, 32'h0);
    summarize();
  end

endmodule

`default_nettype wire
